// ==== verilog/txe_symbol_encoder.sv ====
// 100BASE-TX transmit coding path: 4B/5B, scrambler, NRZI, MLT-3
// Summary of operation
// - Each data nibble is sent as its fixed 5-bit code-group from the sixteen-entry table.
// - The first eight preamble bits of a packet are replaced by the J then K code-groups.
// - After J/K every remaining preamble and data nibble is encoded without substitution.
// - When transmit enable drops, T then R code-groups are appended.
// - After T/R, IDLE code-groups fill the line until transmit enable returns.
// - Pattern 00100 is the HALT code-group, distinct from all data and delimiters.
// - On decode J and K give nibble 0101, while IDLE, T and R give 0000.
// - Unassigned patterns, and control code-groups inside data, decode as invalid.
// - The serial code-group stream is XORed with an 11-bit closed-loop LFSR output.
// - The scrambler seed is taken from the five PHY address straps.
// - A bypass input skips the scrambler.
// - The scrambled stream is NRZI encoded, toggling on each one.
// - Ones alternate between two binary drive phases, forming MLT-3.
// - MLT-3 drive phases and the NRZI line are both output, at one bit per 125 MHz serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "txe_cfg.svh"
module txe_symbol_encoder
	import txe_pkg::*;
#(
	parameter int SYM_BITS = `TXE_SYM_BITS
) (
	input wire logic clk,
	input wire logic reset,
	input wire txe_mii_t mii,
	input wire logic [4:0] phy_address_straps,
	input wire logic scramble_bypass,
	input wire logic [4:0] decode_code,
	input wire logic decode_in_data,
	output logic nibble_req,
	output txe_mlt3_t mlt3,
	output logic nrzi_line,
	output txe_decode_t decoded,
	output logic halt_seen
);

	// Elaboration-time width check
	if (SYM_BITS != 5) begin : g_bad_width
		$error("Code-groups must be five bits wide");
	end

	txe_state_t state;
	logic [2:0] bit_idx;
	logic [4:0] shreg;
	logic [3:0] held_nib;
	logic held_en;
	logic [10:0] lfsr;
	logic seeded;
	logic nrzi_level;
	logic mlt_phase;
	logic [4:0] next_sym;
	txe_state_t next_state;
	logic sym_end;
	logic scr_bit;

	function automatic logic [4:0] enc5(input logic [3:0] n);
		case (n)
			4'h0: enc5 = 5'h1e;
			4'h1: enc5 = 5'h09;
			4'h2: enc5 = 5'h14;
			4'h3: enc5 = 5'h15;
			4'h4: enc5 = 5'h0a;
			4'h5: enc5 = 5'h0b;
			4'h6: enc5 = 5'h0e;
			4'h7: enc5 = 5'h0f;
			4'h8: enc5 = 5'h12;
			4'h9: enc5 = 5'h13;
			4'ha: enc5 = 5'h16;
			4'hb: enc5 = 5'h17;
			4'hc: enc5 = 5'h1a;
			4'hd: enc5 = 5'h1b;
			4'he: enc5 = 5'h1c;
			default: enc5 = 5'h1d;
		endcase
	endfunction

	assign sym_end = (bit_idx == 3'h4);

	// Symbol selection at each code-group boundary
	always_comb begin
		next_state = state;
		next_sym = `TXE_CG_IDLE;
		case (state)
			TXE_IDLE: begin
				if (held_en) begin
					next_state = TXE_K;
					next_sym = `TXE_CG_J;
				end else begin
					next_sym = `TXE_CG_IDLE;
				end
			end
			TXE_J: begin
				next_state = TXE_K;
				next_sym = `TXE_CG_J;
			end
			TXE_K: begin
				next_state = TXE_DATA;
				next_sym = `TXE_CG_K;
			end
			TXE_DATA: begin
				if (held_en) begin
					next_sym = enc5(held_nib);
				end else begin
					next_state = TXE_R;
					next_sym = `TXE_CG_T;
				end
			end
			TXE_R: begin
				next_state = TXE_IDLE;
				next_sym = `TXE_CG_R;
			end
			default: begin
				next_state = TXE_IDLE;
				next_sym = `TXE_CG_IDLE;
			end
		endcase
	end

	// Nibble capture once per code-group; preamble nibbles under J/K are consumed
	always_ff @(posedge clk) begin
		if (reset) begin
			held_nib <= 4'h0;
			held_en <= 1'b0;
		end else if (sym_end) begin
			held_nib <= mii.txd;
			held_en <= mii.tx_en;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			nibble_req <= 1'b0;
		else
			nibble_req <= (bit_idx == 3'h3);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= TXE_IDLE;
			bit_idx <= 3'h0;
			shreg <= `TXE_CG_IDLE;
		end else if (sym_end) begin
			state <= next_state;
			bit_idx <= 3'h0;
			shreg <= next_sym;
		end else begin
			bit_idx <= bit_idx + 3'h1;
			shreg <= {shreg[3:0], 1'b0};
		end
	end

	// Seed from straps caught on first clock after reset
	always_ff @(posedge clk) begin
		if (reset) begin
			lfsr <= `TXE_LFSR_RESET;
			seeded <= 1'b0;
		end else if (!seeded) begin
			lfsr <= {phy_address_straps, ~phy_address_straps, 1'b1};
			seeded <= 1'b1;
		end else begin
			lfsr <= {lfsr[9:0], lfsr[10] ^ lfsr[`TXE_LFSR_TAP]};
		end
	end

	assign scr_bit = scramble_bypass ? shreg[4] : (shreg[4] ^ lfsr[10]);

	// NRZI then MLT-3 phase split, one bit per serial clock
	always_ff @(posedge clk) begin
		if (reset) begin
			nrzi_level <= 1'b0;
			mlt_phase <= 1'b0;
			mlt3 <= '0;
		end else begin
			if (scr_bit) begin
				nrzi_level <= ~nrzi_level;
				mlt_phase <= ~mlt_phase;
			end
			mlt3.drive_pos <= scr_bit & ~mlt_phase;
			mlt3.drive_neg <= scr_bit & mlt_phase;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			nrzi_line <= 1'b0;
		else
			nrzi_line <= nrzi_level ^ scr_bit;
	end

	// Shared code-table decode
	always_ff @(posedge clk) begin
		if (reset) begin
			decoded <= '0;
			halt_seen <= 1'b0;
		end else begin
			halt_seen <= (decode_code == `TXE_CG_HALT);
			decoded.control <= 1'b0;
			decoded.invalid <= 1'b0;
			decoded.nibble <= 4'h0;
			case (decode_code)
				`TXE_CG_J, `TXE_CG_K: begin
					decoded.nibble <= `TXE_NIB_JK;
					decoded.control <= 1'b1;
					decoded.invalid <= decode_in_data;
				end
				`TXE_CG_IDLE, `TXE_CG_T, `TXE_CG_R: begin
					decoded.nibble <= `TXE_NIB_IDLE;
					decoded.control <= 1'b1;
					decoded.invalid <= decode_in_data;
				end
				`TXE_CG_HALT: begin
					decoded.control <= 1'b1;
					decoded.invalid <= 1'b1;
				end
				5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c: begin
					decoded.invalid <= 1'b1;
				end
				default: begin
					// Patterns outside the table stay invalid
					decoded.invalid <= 1'b1;
					for (int i = 0; i < 16; i++) begin
						if (enc5(4'(i)) == decode_code) begin
							decoded.nibble <= 4'(i);
							decoded.invalid <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	property p_jk_after_en;
		@(posedge clk) disable iff (reset)
		(sym_end && state == TXE_IDLE && held_en) |=> (shreg == `TXE_CG_J) ##5 (shreg == `TXE_CG_K);
	endproperty
	a_jk_after_en: assert property (p_jk_after_en)
		else $error("J/K not sent at packet start");
	property p_tr_after_drop;
		@(posedge clk) disable iff (reset)
		(sym_end && state == TXE_DATA && !held_en) |=> (shreg == `TXE_CG_T) ##5 (shreg == `TXE_CG_R);
	endproperty
	a_tr_after_drop: assert property (p_tr_after_drop)
		else $error("T/R not sent at packet end");
	property p_idle_fill;
		@(posedge clk) disable iff (reset)
		(sym_end && state == TXE_IDLE && !held_en) |=> (shreg == `TXE_CG_IDLE);
	endproperty
	a_idle_fill: assert property (p_idle_fill)
		else $error("Idle fill missing");
	property p_data_enc;
		@(posedge clk) disable iff (reset)
		(sym_end && state == TXE_DATA && held_en && held_nib == 4'h0) |=> (shreg == 5'h1e);
	endproperty
	a_data_enc: assert property (p_data_enc)
		else $error("Nibble 0 misencoded");
	property p_nrzi;
		@(posedge clk) disable iff (reset)
		seeded |=> ((nrzi_level != $past(nrzi_level)) == $past(scr_bit));
	endproperty
	a_nrzi: assert property (p_nrzi)
		else $error("NRZI toggle wrong");
	property p_mlt_excl;
		@(posedge clk) disable iff (reset)
		!(mlt3.drive_pos && mlt3.drive_neg);
	endproperty
	a_mlt_excl: assert property (p_mlt_excl)
		else $error("Both drive phases active");
	// Line must toggle exactly on unscrambled ones while bypassed
	property p_bypass;
		@(posedge clk) disable iff (reset)
		scramble_bypass |=> ((nrzi_line != $past(nrzi_line)) == $past(shreg[4]));
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("Bypass did not skip scrambler");
	property p_decode_jk;
		@(posedge clk) disable iff (reset)
		(decode_code == `TXE_CG_K) |=> (decoded.nibble == `TXE_NIB_JK);
	endproperty
	a_decode_jk: assert property (p_decode_jk)
		else $error("K decode wrong");
	property p_decode_inv;
		@(posedge clk) disable iff (reset)
		(decode_code == 5'h00) |=> decoded.invalid;
	endproperty
	a_decode_inv: assert property (p_decode_inv)
		else $error("Unassigned code not invalid");
	property p_halt;
		@(posedge clk) disable iff (reset)
		(decode_code == `TXE_CG_HALT) |=> (halt_seen && decoded.invalid);
	endproperty
	a_halt: assert property (p_halt)
		else $error("Halt not flagged");
	property p_seed;
		@(posedge clk) disable iff (reset)
		!seeded |=> (lfsr[10:6] == $past(phy_address_straps));
	endproperty
	a_seed: assert property (p_seed)
		else $error("Seed not from straps");
	property p_lfsr;
		@(posedge clk) disable iff (reset)
		(seeded && $past(seeded)) |-> (lfsr[0] == ($past(lfsr[10]) ^ $past(lfsr[8])));
	endproperty
	a_lfsr: assert property (p_lfsr)
		else $error("LFSR feedback wrong");

endmodule // txe_symbol_encoder
`default_nettype wire

// ==== common/txe_cfg.svh ====
// Constants for the 100BASE-TX transmit symbol encoder
`ifndef TXE_CFG_SVH
`define TXE_CFG_SVH
`define TXE_CG_J 5'h18
`define TXE_CG_K 5'h11
`define TXE_CG_T 5'h0d
`define TXE_CG_R 5'h07
`define TXE_CG_IDLE 5'h1f
`define TXE_CG_HALT 5'h04
`define TXE_NIB_JK 4'h5
`define TXE_NIB_IDLE 4'h0
`define TXE_LFSR_W 11
`define TXE_LFSR_TAP 8
`define TXE_LFSR_RESET 11'h7ff
`define TXE_SYM_BITS 5
`define TXE_SER_RATE_MBPS 125
`endif

// ==== common/txe_pkg.sv ====
// Types for the 100BASE-TX transmit symbol encoder
package txe_pkg;
	typedef enum logic [2:0] {
		TXE_IDLE,
		TXE_J,
		TXE_K,
		TXE_DATA,
		TXE_T,
		TXE_R
	} txe_state_t;
	typedef struct packed {
		logic tx_en;
		logic [3:0] txd;
	} txe_mii_t;
	typedef struct packed {
		logic drive_pos;
		logic drive_neg;
	} txe_mlt3_t;
	typedef struct packed {
		logic [3:0] nibble;
		logic control;
		logic invalid;
	} txe_decode_t;
endpackage

// ==== tb/txe_mac_model.sv ====
// MAC-side nibble source for the transmit encoder
`timescale 1ns/1ps
`default_nettype none
module txe_mac_model
	import txe_pkg::*;
(
	input wire logic clk,
	input wire logic nibble_req,
	output txe_mii_t mii
);
	logic [3:0] nibs[$];
	initial mii = '0;
	// One nibble per request, enable drops once the frame is used up
	always @(negedge clk) begin
		if (nibble_req) begin
			if (nibs.size() > 0) begin
				mii.tx_en <= 1'b1;
				mii.txd <= nibs.pop_front();
			end else begin
				mii.tx_en <= 1'b0;
				mii.txd <= ~mii.txd;
			end
		end
	end
endmodule // txe_mac_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the transmit symbol encoder
`timescale 1ns/1ps
`default_nettype none
`include "txe_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t got %h want %h", $time, (a), (b)); end end
module tb_top
	import txe_pkg::*;
;
	localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	logic clk = 0, reset = 1, bypass = 1, in_data = 0, prev = 0, aligned = 0, last_pos = 0, seen = 0;
	logic nibble_req, nrzi_line, halt_seen, en, jk, ctl;
	logic [4:0] straps = 0, code = 0, sym;
	logic [3:0] n;
	logic [9:0] win = 0, sa;
	txe_mii_t mii;
	txe_mlt3_t mlt3;
	txe_decode_t decoded;
	int error_cnt = 0, tests_run = 0, nb = 0, ones = 0, pulses = 0, zeros = 0, z0;
	logic [4:0] expq[$];
	always #5 clk = ~clk;
	txe_mac_model u_mac (.clk(clk), .nibble_req(nibble_req), .mii(mii));
	txe_symbol_encoder u_txe_symbol_encoder (.clk(clk), .reset(reset), .mii(mii), .phy_address_straps(straps),
		.scramble_bypass(bypass), .decode_code(code), .decode_in_data(in_data), .nibble_req(nibble_req),
		.mlt3(mlt3), .nrzi_line(nrzi_line), .decoded(decoded), .halt_seen(halt_seen));
	// Recover line bits, align on J/K, compare each symbol with the oldest note
	always @(negedge clk) begin
		if (!reset) begin
			win = {win[8:0], nrzi_line ^ prev};
			ones += win[0];
			zeros += !win[0];
			if (bypass && !aligned && win == {`TXE_CG_J, `TXE_CG_K}) begin
				aligned = 1;
				nb = 0;
			end else if (aligned && ++nb == 5) begin
				nb = 0;
				if (expq.size() > 0) begin
					sym = expq.pop_front();
					`CHK(win[4:0], sym)
				end
				// Drop alignment as the last note is used, before the next frame is queued
				aligned = expq.size() > 0;
			end
			if (mlt3.drive_pos || mlt3.drive_neg) begin
				pulses++;
				`CHK(mlt3.drive_pos ^ mlt3.drive_neg, 1'b1)
				if (seen) `CHK(mlt3.drive_pos, ~last_pos)
				last_pos = mlt3.drive_pos;
				seen = 1;
			end
		end else begin
			// Phase restarts on reset
			seen = 0;
		end
		prev = nrzi_line;
	end
	task automatic report_and_stop;
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic do_reset(input int c);
		reset = 1'b1;
		repeat (c) @(negedge clk);
		reset = 1'b0;
	endtask
	task automatic send(input int c, input bit walk);
		logic [3:0] d;
		u_mac.nibs.push_back(4'h5);
		u_mac.nibs.push_back(4'h5);
		for (int i = 0; i < c; i++) begin
			d = walk ? i[3:0] : 4'($urandom);
			u_mac.nibs.push_back(d);
			expq.push_back(ENC[d]);
		end
		expq.push_back(`TXE_CG_T);
		expq.push_back(`TXE_CG_R);
		expq.push_back(`TXE_CG_IDLE);
		expq.push_back(`TXE_CG_IDLE);
		for (int i = 0; i < 10 * c + 200 && expq.size() > 0; i++) @(negedge clk);
		`CHK(expq.size(), 0)
	endtask
	initial begin
		#100000;
		error_cnt++;
		report_and_stop;
	end
	initial begin
		void'($urandom(62265));
		@(negedge clk);
		do_reset(8);
		repeat (20) @(negedge clk);
		z0 = zeros;
		repeat (64) @(negedge clk);
		`CHK(zeros - z0, 0)
		for (int c = 0; c < 64; c++) begin
			code = c[4:0];
			in_data = c[5];
			@(negedge clk);
			en = 0;
			n = 0;
			for (int i = 0; i < 16; i++) if (ENC[i] == code) begin en = 1; n = i[3:0]; end
			jk = code == `TXE_CG_J || code == `TXE_CG_K;
			ctl = jk || code == `TXE_CG_IDLE || code == `TXE_CG_T || code == `TXE_CG_R;
			if (en || ctl) `CHK({decoded.nibble, decoded.control}, {jk ? `TXE_NIB_JK : n, ctl})
			`CHK(decoded.invalid, !(en || (ctl && !in_data)))
			`CHK(halt_seen, code == `TXE_CG_HALT)
		end
		send(16, 1);
		send(1, 0);
		send(30, 0);
		send(2, 0);
		`CHK((ones - pulses) inside {[-2:2]}, 1'b1)
		bypass = 1'b0;
		straps = 5'($urandom);
		do_reset(2);
		repeat (40) @(negedge clk);
		sa = win;
		z0 = zeros;
		repeat (64) @(negedge clk);
		`CHK(zeros > z0, 1'b1)
		straps = ~straps;
		do_reset(2);
		repeat (40) @(negedge clk);
		`CHK(win != sa, 1'b1)
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
